// ### hw/led_pkg.sv
// Function
// - Threshold equals observed noise times 5-bit noise factor, default 12.
// - 3-bit peak factor scales noise peak; default 3 means factor 1.5.
// - Analysis loads read-only 16-bit index of the strongest accumulator path.
// - Analysis loads read-only 16-bit magnitude found at that peak index.
// - 16-bit read-write receive antenna delay, one LSB about 15.65 ps.
// - Adjusted timestamp is raw timestamp minus antenna delay plus first path adjust.
// - Threshold raised by factor from clock offset and replica coefficient.
package led_pkg;

  // Bus and datapath widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W = 16;
  localparam int unsigned MAG_W = 16;
  localparam int unsigned THR_W = 24;
  localparam int unsigned OFS_W = 8;
  localparam int unsigned TS_W = 40;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_THR_CFG = 16'h0806;
  localparam logic [ADDR_W-1:0] OFS_PEAK_IDX = 16'h1000;
  localparam logic [ADDR_W-1:0] OFS_PEAK_AMP = 16'h1002;
  localparam logic [ADDR_W-1:0] OFS_ANT_DLY = 16'h1804;
  localparam logic [ADDR_W-1:0] OFS_PRF_TUNE = 16'h1806;
  localparam logic [ADDR_W-1:0] OFS_REPL_COEF = 16'h2804;

  // Threshold config field layout
  localparam int unsigned NTF_LSB = 0;
  localparam int unsigned NTF_W = 5;
  localparam int unsigned PSF_LSB = 5;
  localparam int unsigned PSF_W = 3;
  localparam int unsigned CFG1_W = 8;

  // Reset values
  localparam logic [CFG1_W-1:0] CFG1_RST = 8'h6C;
  localparam logic [DATA_W-1:0] ANT_DLY_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PRF_TUNE_RST = 16'h1607;
  localparam logic [DATA_W-1:0] REPL_COEF_RST = 16'h5998;

  // Tuning words software is expected to use
  localparam logic [DATA_W-1:0] PRF_TUNE_16M = 16'h1607;
  localparam logic [DATA_W-1:0] PRF_TUNE_64M = 16'h0607;

  // Fixed point scaling of the threshold arithmetic
  localparam int unsigned NTF_SHIFT = 0;
  localparam int unsigned PSF_SHIFT = 1;
  localparam int unsigned REPL_SHIFT = 15;
  localparam int unsigned OFS_SHIFT = 4;

  // Analysis sequencer, Gray coded along idle, scan, finish
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_FINISH = 2'b11
  } led_state_e;

  // One accumulator sample or a found path
  typedef struct packed {
    logic [IDX_W-1:0] index;
    logic [MAG_W-1:0] mag;
  } led_sample_s;

  // Noise estimates and clock offset entering the threshold
  typedef struct packed {
    logic [MAG_W-1:0] noise_level;
    logic [MAG_W-1:0] noise_peak;
    logic [OFS_W-1:0] clock_offset;
  } led_noise_s;

endpackage

// ### hw/led_peak_track.sv
`timescale 1ns/1ns
// Tracks strongest path and first threshold crossing over one accumulator scan
module led_peak_track (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic [led_pkg::THR_W-1:0] threshold,
  // Sample stream
  input wire logic smp_valid,
  input wire led_pkg::led_sample_s smp,
  // Results
  output led_pkg::led_sample_s best,
  output logic best_found,
  output logic [led_pkg::IDX_W-1:0] first_idx,
  output logic first_found
);

  typedef struct packed {
    led_pkg::led_sample_s best;
    logic have;
    logic [led_pkg::IDX_W-1:0] fp;
    logic fp_have;
  } led_track_s;

  led_track_s st_q;
  led_track_s st_d;

  // Strict greater keeps the earliest of equal peaks
  always_comb
  begin
    st_d = st_q;
    if (clear)
    begin
      st_d = '0;
    end
    else if (smp_valid)
    begin
      if (!st_q.have || (smp.mag > st_q.best.mag))
      begin
        st_d.best = smp;
        st_d.have = 1'b1;
      end
      if (!st_q.fp_have && ({8'h00, smp.mag} >= threshold))
      begin
        st_d.fp = smp.index;
        st_d.fp_have = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Results straight from flip-flops
  assign best = st_q.best;
  assign best_found = st_q.have;
  assign first_idx = st_q.fp;
  assign first_found = st_q.fp_have;

endmodule

// ### hw/led_regs.sv
`timescale 1ns/1ns
// Leading edge detector configuration and status registers with analysis control
module led_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [led_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [led_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [led_pkg::DATA_W-1:0] reg_rdata,
  // Analysis control
  input wire logic analysis_start,
  input wire led_pkg::led_noise_s noise_in,
  // Accumulator sample stream
  input wire logic acc_valid,
  input wire logic acc_last,
  input wire led_pkg::led_sample_s acc_sample,
  // Timestamp path
  input wire logic [led_pkg::TS_W-1:0] raw_rx_timestamp,
  output logic [led_pkg::TS_W-1:0] adjusted_rx_timestamp,
  output logic timestamp_valid,
  // Status to neighbouring logic
  output logic [led_pkg::THR_W-1:0] threshold_report,
  output logic [led_pkg::IDX_W-1:0] first_path_index,
  output logic analysis_busy,
  output logic analysis_done,
  // Configuration outputs to the receiver
  output logic [led_pkg::DATA_W-1:0] prf_tuning_word,
  output logic [led_pkg::DATA_W-1:0] replica_coefficient
);

  typedef struct packed {
    led_pkg::led_state_e state;
    logic [led_pkg::CFG1_W-1:0] lde_threshold_config;
    logic [led_pkg::DATA_W-1:0] rx_antenna_delay;
    logic [led_pkg::DATA_W-1:0] prf_tuning_word;
    logic [led_pkg::DATA_W-1:0] replica_coefficient;
    led_pkg::led_sample_s peak;
    logic [led_pkg::THR_W-1:0] thr;
    logic [led_pkg::IDX_W-1:0] fp_idx;
    logic [led_pkg::TS_W-1:0] ts;
    logic ts_valid;
    logic done;
    logic [led_pkg::DATA_W-1:0] rdata;
  } led_regs_s;

  led_regs_s st_q;
  led_regs_s st_d;

  // Tracker connections
  logic trk_clear;
  led_pkg::led_sample_s trk_best;
  logic trk_best_found;
  logic [led_pkg::IDX_W-1:0] trk_first_idx;
  logic trk_first_found;

  // Threshold arithmetic
  logic [led_pkg::NTF_W-1:0] noise_threshold_factor;
  logic [led_pkg::PSF_W-1:0] peak_scale_factor;
  logic [led_pkg::THR_W-1:0] thr_noise;
  logic [led_pkg::THR_W-1:0] thr_peak;
  logic [led_pkg::THR_W-1:0] thr_base;
  logic [led_pkg::THR_W-1:0] thr_raise;
  logic [led_pkg::THR_W-1:0] thr_final;

  // Multiply, shift right and saturate at threshold width
  function automatic logic [led_pkg::THR_W-1:0] mul_shift(
    input logic [led_pkg::THR_W-1:0] a,
    input logic [led_pkg::DATA_W-1:0] b,
    input int unsigned sh
  );
    logic [led_pkg::THR_W+led_pkg::DATA_W-1:0] prod;
    prod = a * b;
    prod = prod >> sh;
    if (|prod[led_pkg::THR_W+led_pkg::DATA_W-1:led_pkg::THR_W])
    begin
      mul_shift = '1;
    end
    else
    begin
      mul_shift = prod[led_pkg::THR_W-1:0];
    end
  endfunction

  // Saturating add keeps a huge raise from wrapping to a tiny threshold
  function automatic logic [led_pkg::THR_W-1:0] sat_add(
    input logic [led_pkg::THR_W-1:0] a,
    input logic [led_pkg::THR_W-1:0] b
  );
    logic [led_pkg::THR_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat_add = sum[led_pkg::THR_W] ? '1 : sum[led_pkg::THR_W-1:0];
  endfunction

  // Field extraction from the threshold config register
  assign noise_threshold_factor =
    st_q.lde_threshold_config[led_pkg::NTF_LSB +: led_pkg::NTF_W];
  assign peak_scale_factor =
    st_q.lde_threshold_config[led_pkg::PSF_LSB +: led_pkg::PSF_W];

  // Threshold: larger of scaled noise level and scaled noise peak, then replica raise
  always_comb
  begin
    thr_noise = mul_shift({8'h00, noise_in.noise_level},
                          {11'h000, noise_threshold_factor},
                          led_pkg::NTF_SHIFT);
    thr_peak = mul_shift({8'h00, noise_in.noise_peak},
                         {13'h0000, peak_scale_factor},
                         led_pkg::PSF_SHIFT);
    thr_base = (thr_peak > thr_noise) ? thr_peak : thr_noise;
    thr_raise = mul_shift(mul_shift(thr_base, st_q.replica_coefficient,
                                    led_pkg::REPL_SHIFT),
                          {8'h00, noise_in.clock_offset},
                          led_pkg::OFS_SHIFT);
    thr_final = sat_add(thr_base, thr_raise);
  end

  // Peak and first path search over the scan
  led_peak_track u_track (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(trk_clear),
    .threshold(st_q.thr),
    .smp_valid(acc_valid && (st_q.state == led_pkg::ST_SCAN)),
    .smp(acc_sample),
    .best(trk_best),
    .best_found(trk_best_found),
    .first_idx(trk_first_idx),
    .first_found(trk_first_found)
  );

  // Tracker is wiped when a new analysis begins
  assign trk_clear = analysis_start && (st_q.state == led_pkg::ST_IDLE);

  // Next state: register writes, read data and analysis sequencing
  always_comb
  begin
    st_d = st_q;
    st_d.ts_valid = 1'b0;
    st_d.done = 1'b0;

    // Writes; only the low byte lands in the 8-bit config register
    if (reg_wr)
    begin
      unique case (reg_addr)
        led_pkg::OFS_THR_CFG:
        begin
          st_d.lde_threshold_config = reg_wdata[led_pkg::CFG1_W-1:0];
        end
        led_pkg::OFS_ANT_DLY:
        begin
          st_d.rx_antenna_delay = reg_wdata;
        end
        led_pkg::OFS_PRF_TUNE:
        begin
          st_d.prf_tuning_word = reg_wdata;
        end
        led_pkg::OFS_REPL_COEF:
        begin
          st_d.replica_coefficient = reg_wdata;
        end
        default:
        begin
          // Status and unmapped offsets ignore writes
          st_d.peak = st_q.peak;
        end
      endcase
    end

    // Read data valid only in the cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        led_pkg::OFS_THR_CFG:
        begin
          st_d.rdata = {8'h00, st_q.lde_threshold_config};
        end
        led_pkg::OFS_PEAK_IDX:
        begin
          st_d.rdata = st_q.peak.index;
        end
        led_pkg::OFS_PEAK_AMP:
        begin
          st_d.rdata = st_q.peak.mag;
        end
        led_pkg::OFS_ANT_DLY:
        begin
          st_d.rdata = st_q.rx_antenna_delay;
        end
        led_pkg::OFS_PRF_TUNE:
        begin
          st_d.rdata = st_q.prf_tuning_word;
        end
        led_pkg::OFS_REPL_COEF:
        begin
          st_d.rdata = st_q.replica_coefficient;
        end
        default:
        begin
          st_d.rdata = '0;
        end
      endcase
    end

    // Analysis sequencer
    unique case (st_q.state)
      led_pkg::ST_IDLE:
      begin
        if (analysis_start)
        begin
          // Threshold frozen for the whole scan so later config writes cannot skew it
          st_d.thr = thr_final;
          st_d.state = led_pkg::ST_SCAN;
        end
      end
      led_pkg::ST_SCAN:
      begin
        if (acc_valid && acc_last)
        begin
          st_d.state = led_pkg::ST_FINISH;
        end
      end
      led_pkg::ST_FINISH:
      begin
        // Status only changes here, so it holds between analyses
        if (trk_best_found)
        begin
          st_d.peak = trk_best;
        end
        st_d.fp_idx = trk_first_found ? trk_first_idx : trk_best.index;
        // Antenna delay removed, first path position added
        st_d.ts = raw_rx_timestamp
                  - {24'h00_0000, st_q.rx_antenna_delay}
                  + {24'h00_0000, st_d.fp_idx};
        st_d.ts_valid = 1'b1;
        st_d.done = 1'b1;
        st_d.state = led_pkg::ST_IDLE;
      end
      default:
      begin
        // The one unused code falls back to idle so the sequencer cannot lock up
        st_d.state = led_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.state <= led_pkg::ST_IDLE;
      st_q.lde_threshold_config <= led_pkg::CFG1_RST;
      st_q.rx_antenna_delay <= led_pkg::ANT_DLY_RST;
      st_q.prf_tuning_word <= led_pkg::PRF_TUNE_RST;
      st_q.replica_coefficient <= led_pkg::REPL_COEF_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs from flip-flops; busy is a plain decode of the state
  assign reg_rdata = st_q.rdata;
  assign adjusted_rx_timestamp = st_q.ts;
  assign timestamp_valid = st_q.ts_valid;
  assign threshold_report = st_q.thr;
  assign first_path_index = st_q.fp_idx;
  assign analysis_busy = (st_q.state != led_pkg::ST_IDLE);
  assign analysis_done = st_q.done;
  assign prf_tuning_word = st_q.prf_tuning_word;
  assign replica_coefficient = st_q.replica_coefficient;

endmodule

// ### verification/led_regs_props.sv
`timescale 1ns/1ns
module led_regs_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [led_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [led_pkg::DATA_W-1:0] reg_rdata,
  // Analysis
  input wire logic analysis_start,
  input wire logic acc_valid,
  input wire logic acc_last,
  input wire logic [led_pkg::TS_W-1:0] adjusted_rx_timestamp,
  input wire logic timestamp_valid,
  input wire logic [led_pkg::THR_W-1:0] threshold_report,
  input wire logic analysis_busy,
  input wire logic analysis_done
);
  logic cfg_wr_q;
  logic cfg_wr_d;
  // Any config write since reset means the default may be gone
  always_comb cfg_wr_d = cfg_wr_q | (reg_wr && reg_addr == led_pkg::OFS_THR_CFG);
  always_ff @(posedge sys_clk) cfg_wr_q <= rst ? 1'b0 : cfg_wr_d;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Scan end and the wrap-up cycle that follows it
  sequence s_last;
    analysis_busy && acc_valid && acc_last;
  endsequence
  sequence s_wrap;
    analysis_busy ##1 (analysis_done && !analysis_busy);
  endsequence
  property p_finish;
    s_last |=> s_wrap;
  endproperty
  a_finish: assert property (p_finish) else $error("done late");
  property p_start;
    analysis_start && !analysis_busy |=> analysis_busy [*2];
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_done_src;
    analysis_done |-> $past(analysis_busy) && !analysis_busy;
  endproperty
  a_done_src: assert property (p_done_src) else $error("done without scan");
  property p_ts_done;
    1'b1 |-> timestamp_valid == analysis_done;
  endproperty
  a_ts_done: assert property (p_ts_done) else $error("ts pulse apart");
  property p_ts_hold;
    !timestamp_valid |-> $stable(adjusted_rx_timestamp);
  endproperty
  a_ts_hold: assert property (p_ts_hold) else $error("ts moved");
  property p_thr_hold;
    analysis_busy && $past(analysis_busy) |-> $stable(threshold_report);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved");
  property p_cfg_rst;
    reg_rd && reg_addr == led_pkg::OFS_THR_CFG && !cfg_wr_q |=>
      reg_rdata == {8'h00, led_pkg::CFG1_RST};
  endproperty
  a_cfg_rst: assert property (p_cfg_rst) else $error("cfg default");
  property p_cfg_byte;
    reg_rd && reg_addr == led_pkg::OFS_THR_CFG |=> reg_rdata[15:8] == 8'h00;
  endproperty
  a_cfg_byte: assert property (p_cfg_byte) else $error("cfg upper byte");
endmodule
bind led_regs led_regs_props led_regs_props_inst (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .analysis_start(analysis_start), .acc_valid(acc_valid), .acc_last(acc_last),
  .adjusted_rx_timestamp(adjusted_rx_timestamp), .timestamp_valid(timestamp_valid),
  .threshold_report(threshold_report), .analysis_busy(analysis_busy),
  .analysis_done(analysis_done));

// ### verification/tb.sv
`timescale 1ns/1ns
module tb;
  logic sys_clk = 0;
  logic rst = 1;
  logic [15:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic analysis_start = 0;
  logic acc_valid = 0;
  logic acc_last = 0;
  led_pkg::led_noise_s noise_in = '0;
  led_pkg::led_sample_s acc_sample = '0;
  logic [39:0] raw_rx_timestamp = 0;
  logic [15:0] reg_rdata, first_path_index, prf_tuning_word, replica_coefficient;
  logic [39:0] adjusted_rx_timestamp;
  logic [23:0] threshold_report;
  logic timestamp_valid, analysis_busy, analysis_done;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h31e7;
  logic [15:0] rv, v, antd, repc;
  logic [7:0] cfg;
  logic [15:0] tab [24] = '{16'h5998, 16'h5998, 16'h51EA, 16'h428E, 16'h451E, 16'h2E14,
    16'h8000, 16'h51EA, 16'h28F4, 16'h3332, 16'h3AE0, 16'h3D70, 16'h3AE0, 16'h35C2,
    16'h2B84, 16'h35C2, 16'h3332, 16'h35C2, 16'h35C2, 16'h47AE, 16'h3AE0, 16'h3850,
    16'h30A2, 16'h3850};
  logic [15:0] ra [7] = '{16'h0806, 16'h1000, 16'h1002, 16'h1804, 16'h1806, 16'h2804, 16'h0};
  logic [15:0] re [7] = '{16'h006C, 16'h0, 16'h0, 16'h0, 16'h1607, 16'h5998, 16'h0};

  // Free-running system clock
  always #25 sys_clk = ~sys_clk;

  led_regs led_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .analysis_start(analysis_start), .noise_in(noise_in), .acc_valid(acc_valid),
    .acc_last(acc_last), .acc_sample(acc_sample), .raw_rx_timestamp(raw_rx_timestamp),
    .adjusted_rx_timestamp(adjusted_rx_timestamp), .timestamp_valid(timestamp_valid),
    .threshold_report(threshold_report), .first_path_index(first_path_index),
    .analysis_busy(analysis_busy), .analysis_done(analysis_done),
    .prf_tuning_word(prf_tuning_word), .replica_coefficient(replica_coefficient));

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One-cycle bus strobes; read data is taken in the cycle after the strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask

  // Small noise keeps every step far below saturation
  function automatic logic [23:0] thr_f(input led_pkg::led_noise_s n);
    logic [47:0] b1, b2;
    b1 = n.noise_level * cfg[4:0];
    b2 = (n.noise_peak * cfg[7:5]) >> 1;
    if (b2 > b1)
      b1 = b2;
    b2 = (((b1 * repc) >> 15) * n.clock_offset) >> 4;
    return 24'(b1 + b2);
  endfunction

  task automatic run(input int n);
    led_pkg::led_noise_s nz;
    logic [39:0] raw;
    logic [15:0] m, pk, pi, fp;
    logic [23:0] th;
    bit hit;
    nz = {16'($random(seed) & 7), 16'($random(seed) & 63), 8'($random(seed) & 15)};
    raw = {8'($random(seed)), 32'($random(seed))};
    th = thr_f(nz);
    pk = 0;
    pi = 0;
    fp = 0;
    hit = 0;
    @(posedge sys_clk);
    analysis_start <= 1;
    noise_in <= nz;
    raw_rx_timestamp <= raw;
    @(posedge sys_clk);
    analysis_start <= 0;
    for (int i = 0; i < n; i++)
    begin
      // A gap carrying a huge but invalid sample must be ignored
      if (i == 1)
      begin
        acc_valid <= 0;
        acc_sample <= '1;
        @(posedge sys_clk);
      end
      m = (i == 2) ? pk : 16'($random(seed) & 511);
      acc_valid <= 1;
      acc_last <= (i == n - 1);
      acc_sample <= {16'(i * 3 + 5), m};
      if (i == 0 || m > pk)
      begin
        pk = m;
        pi = 16'(i * 3 + 5);
      end
      if (!hit && m >= th)
      begin
        hit = 1;
        fp = 16'(i * 3 + 5);
      end
      @(posedge sys_clk);
    end
    acc_valid <= 0;
    acc_last <= 0;
    if (!hit)
      fp = pi;
    #1;
    for (int k = 0; k < 8 && analysis_done !== 1'b1; k++)
      @(posedge sys_clk) #1;
    if (analysis_done !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
    chk("ts_valid", 1, timestamp_valid);
    chk("thr", th, threshold_report);
    chk("first", fp, first_path_index);
    chk("ts", raw - antd + fp, adjusted_rx_timestamp);
    rd(16'h1000, rv);
    chk("pk_idx", pi, rv);
    rd(16'h1002, rv);
    chk("pk_amp", pk, rv);
    wr(16'h1000, ~pi);
    wr(16'h1002, ~pk);
    rd(16'h1000, rv);
    chk("pk_hold", pi, rv);
    rd(16'h1002, rv);
    chk("amp_hold", pk, rv);
    $display("analysis test done, %0d samples", n);
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    for (int i = 0; i < 7; i++)
    begin
      rd(ra[i], rv);
      chk("reset", re[i], rv);
    end
    $display("reset test done");
    // Upper byte of a wide write to the config byte is dropped
    cfg = 8'($random(seed));
    wr(16'h0806, {8'hA5, cfg});
    rd(16'h0806, rv);
    chk("cfg", {8'h00, cfg}, rv);
    antd = 16'($random(seed));
    wr(16'h1804, antd);
    wr(16'h0000, 16'hFFFF);
    rd(16'h1804, rv);
    chk("antd", antd, rv);
    // Read data stands for one cycle only, then returns to zero
    @(posedge sys_clk) #1;
    chk("rd_idle", 0, reg_rdata);
    rd(16'h0000, rv);
    chk("unmapped", 0, rv);
    for (int i = 0; i < 50; i++)
    begin
      v = (i < 2) ? (i ? 16'h0607 : 16'h1607) : tab[(i - 2) % 24] >> ((i - 2) / 24 * 3);
      wr(i < 2 ? 16'h1806 : 16'h2804, v);
      rd(i < 2 ? 16'h1806 : 16'h2804, rv);
      chk("cfg_rd", v, rv);
      chk("cfg_out", v, i < 2 ? prf_tuning_word : replica_coefficient);
    end
    $display("config test done");
    for (int j = 0; j < 6; j++)
    begin
      cfg = 8'($random(seed));
      repc = tab[j * 4];
      antd = 16'($random(seed));
      wr(16'h0806, {8'h00, cfg});
      wr(16'h2804, repc);
      wr(16'h1804, antd);
      run(j * 3 + 1);
    end
    conclude();
  end
endmodule
